// ### design/sidsp_decide.sv
`default_nettype none
// per-target forward/drop decision, one slice per cpu interface
module sidsp_decide (
  input  wire logic [7:0]  targets,    // interfaces chosen by the filter
  input  wire logic [3:0]  num,        // interrupt number
  input  wire logic        secure,     // write was secure
  input  wire logic        attr,       // attribute_select_bit of the write
  input  wire logic        sec_ext,    // security extensions present
  input  wire logic [127:0] group_flat, // 16 group bits per cpu, cpu 0 lowest
  output logic      [7:0]  forward     // final per-target decision
);
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_cpu
      logic grp1;
      logic want1;
      assign grp1  = group_flat[g*16 + num];
      // a non-secure write cannot pick group 0 whatever bit 15 says
      assign want1 = secure ? attr : 1'b1;
      assign forward[g] = targets[g] & (!sec_ext | (grp1 == want1));
    end
  endgenerate
endmodule
`default_nettype wire

// ### design/sidsp_pkg.sv
`default_nettype none
package sidsp_pkg;
  localparam int unsigned NUM_CPU = 8;

  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] OFF_GENERATE  = 8'h00;
  localparam logic [7:0] OFF_GROUP_CPU = 8'h04;
  localparam logic [7:0] OFF_CONTROL   = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_COUNT     = 8'h10;

  // field positions of software_interrupt_generate
  localparam int unsigned FILTER_LSB = 24;
  localparam int unsigned MASK_LSB   = 16;
  localparam int unsigned ATTR_BIT   = 15;
  localparam int unsigned NUM_LSB    = 0;

  // filter encodings
  localparam logic [1:0] FILT_LIST   = 2'h0;
  localparam logic [1:0] FILT_OTHERS = 2'h1;
  localparam logic [1:0] FILT_SELF   = 2'h2;

  // reset values
  localparam logic [15:0] GROUP_RST   = 16'h0000;
  localparam logic [1:0]  CONTROL_RST = 2'h0;
  localparam logic [7:0]  COUNT_RST   = 8'h00;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        secure;
    logic [2:0]  cpu;
  } sidsp_req_t;

  typedef struct packed {
    logic [7:0] valid;
    logic [3:0] num;
    logic [2:0] source;
  } sidsp_fwd_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DECIDE = 3'b010,
    ST_ISSUE  = 3'b100
  } sidsp_state_t;
endpackage
`default_nettype wire

// ### design/sidsp_top.sv
`default_nettype none
// Functional notes
// - filter 00: deliver to every interface whose mask bit is set
// - filter 01: deliver to all interfaces except the writer's, mask ignored
// - filter 10: deliver only to the writing processor's interface
// - mask bit n selects cpu interface n under list filtering
// - list filtering with zero mask delivers nowhere
// - secure write, attribute bit clear: deliver only where group 0
// - secure write, attribute bit set: deliver only where group 1
// - non-secure write delivers only where group 1, attribute bit ignored
// - without security extensions bit 15 is reserved, no group filtering
// - low four bits give interrupt number 0 to 15
// - forward or drop is decided separately per target
// - group configuration banked per processor, target's copy used
// - writes while forwarding disabled are dropped, chosen behaviour
module sidsp_top (
  input  wire logic               clk,       // 20 MHz clock
  input  wire logic               rstn,      // async reset, active low
  input  wire sidsp_pkg::sidsp_req_t req,    // register access
  input  wire logic               sec_ext,   // security extensions present
  output logic      [31:0]        rdata,     // read data, cycle after read
  output sidsp_pkg::sidsp_fwd_t   fwd        // forwarded interrupt, one-cycle pulse
);
  import sidsp_pkg::*;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [15:0]  group_q [NUM_CPU];
  logic [1:0]   control_q;
  logic [7:0]   count_q;
  logic [7:0]   dropped_q;
  logic [31:0]  rdata_q;
  sidsp_fwd_t   fwd_q;
  sidsp_state_t state_q;
  logic [7:0]   targets_q;
  logic [3:0]   num_q;
  logic         secure_q;
  logic         attr_q;
  logic [2:0]   src_q;
  logic [7:0]   forward;
  logic [127:0] group_flat;
  logic [7:0]   last_targets_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [7:0] onehot(input logic [2:0] c);
    return 8'h01 << c;
  endfunction

  // ----------------------------------------
  // security strap synchroniser
  // ----------------------------------------
  // the strap comes from a pin, so two flops stand before any logic reads it
  logic [1:0] sec_sync_q;
  logic       sec_ext_s;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_sync_q <= 2'h0;
    end else begin
      sec_sync_q <= {sec_sync_q[0], sec_ext};
    end
  end
  assign sec_ext_s = sec_sync_q[1];

  logic gen_wr;
  logic fwd_en;
  assign gen_wr = req.wr & hit(req.addr, OFF_GENERATE);
  assign fwd_en = control_q[0];

  // ----------------------------------------
  // target selection
  // ----------------------------------------
  logic [7:0] targets_d;
  always_comb begin
    case (req.wdata[FILTER_LSB +: 2])
      FILT_LIST:   targets_d = req.wdata[MASK_LSB +: 8];
      FILT_OTHERS: targets_d = ~onehot(req.cpu);
      FILT_SELF:   targets_d = onehot(req.cpu);
      default:     targets_d = 8'h00;
    endcase
  end

  // ----------------------------------------
  // decision pipeline
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= ST_IDLE;
      targets_q <= 8'h00;
      num_q     <= 4'h0;
      secure_q  <= 1'b0;
      attr_q    <= 1'b0;
      src_q     <= 3'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // disabled forwarding drops the write rather than queueing it
          if (gen_wr && fwd_en) begin
            targets_q <= targets_d;
            num_q     <= req.wdata[NUM_LSB +: 4];
            secure_q  <= req.secure;
            attr_q    <= req.wdata[ATTR_BIT] & req.secure & sec_ext_s;
            src_q     <= req.cpu;
            state_q   <= ST_DECIDE;
          end
        end
        ST_DECIDE: state_q <= ST_ISSUE;
        ST_ISSUE:  state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_CPU; c++) begin : g_flat
      assign group_flat[c*16 +: 16] = group_q[c];
    end
  endgenerate

  sidsp_decide u_decide (
    .targets    (targets_q),
    .num        (num_q),
    .secure     (secure_q),
    .attr       (attr_q),
    .sec_ext    (sec_ext_s),
    .group_flat (group_flat),
    .forward    (forward)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fwd_q <= '0;
    end else if (state_q == ST_DECIDE) begin
      fwd_q.valid  <= forward;
      fwd_q.num    <= num_q;
      fwd_q.source <= src_q;
    end else begin
      fwd_q.valid <= 8'h00;
    end
  end

  // ----------------------------------------
  // software-visible registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_CPU; i++) begin
        group_q[i] <= GROUP_RST;
      end
    end else if (req.wr && hit(req.addr, OFF_GROUP_CPU)) begin
      // banked: the writer only touches its own copy
      group_q[req.cpu] <= req.wdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_q <= CONTROL_RST;
    end else if (req.wr && hit(req.addr, OFF_CONTROL)) begin
      control_q <= req.wdata[1:0];
    end
  end

  // counts of decided writes and of writes with a dropped target; bit1 of control clears them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q        <= COUNT_RST;
      dropped_q      <= COUNT_RST;
      last_targets_q <= 8'h00;
    end else if (state_q == ST_DECIDE) begin
      count_q        <= count_q + 8'h01;
      dropped_q      <= dropped_q + {7'h00, (forward != targets_q)};
      last_targets_q <= forward;
    end else if (control_q[1]) begin
      count_q   <= COUNT_RST;
      dropped_q <= COUNT_RST;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else if (req.rd) begin
      case (req.addr)
        OFF_GROUP_CPU: rdata_q <= {16'h0000, group_q[req.cpu]};
        OFF_CONTROL:   rdata_q <= {30'h0, control_q};
        OFF_STATUS:    rdata_q <= {21'h0, state_q, last_targets_q};
        OFF_COUNT:     rdata_q <= {16'h0000, dropped_q, count_q};
        default:       rdata_q <= 32'h0000_0000; // generate reg is write-only
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_q;
  assign fwd   = fwd_q;
endmodule
`default_nettype wire

// ### verif/sidsp_cpu_sink.sv
`default_nettype none
// gathers what the cpu interfaces receive, cleared per write request
module sidsp_cpu_sink (
  input  wire logic                  clk,  // clock
  input  wire logic                  rstn, // async reset, active low
  input  wire logic                  clr,  // start a new capture
  input  wire sidsp_pkg::sidsp_fwd_t fwd,  // forwarded interrupts
  output logic [7:0]                 seen  // interfaces hit since clr
);
  import sidsp_pkg::*;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) seen <= 8'h00;
    else seen <= clr ? 8'h00 : seen | fwd.valid;
  end
endmodule
`default_nettype wire

// ### verif/sidsp_top_bench.sv
`default_nettype none
module sidsp_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sidsp_pkg::*;
  logic clk, rstn, sec_ext, clr;
  sidsp_req_t req;
  logic [31:0] rdata;
  sidsp_fwd_t fwd;
  logic [7:0] seen;
  int fail_count, check_count;
  localparam logic [31:0] W [7] = '{32'h00a5_0004, 32'h0000_8006, 32'h0101_8003,
    32'h0200_0005, 32'h03ff_8001, 32'hfca5_7ff7, 32'h0100_8002};
  localparam logic [6:0] S = 7'h37;
  localparam logic [2:0] C [7] = '{3'h0, 3'h0, 3'h3, 3'h5, 3'h0, 3'h0, 3'h0};
  sidsp_top DUT (.clk(clk), .rstn(rstn), .req(req), .sec_ext(sec_ext), .rdata(rdata), .fwd(fwd));
  sidsp_cpu_sink u_sink (.clk(clk), .rstn(rstn), .clr(clr), .fwd(fwd), .seen(seen));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------
  // access tasks
  // ----------------
  task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [31:0] d, logic s, logic [2:0] c);
    @(posedge clk);
    req <= '{a, d, w, !w, s, c};
    clr <= w;
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    clr <= 1'b0;
  endtask
  // odd cpus hold odd numbers in group 1, even cpus even ones
  function automatic logic [7:0] expect_m(logic [31:0] w, logic s, logic [2:0] c, logic se);
    logic [7:0] t;
    case (w[25:24])
      2'h0: t = w[23:16];
      2'h1: t = ~(8'h01 << c);
      2'h2: t = 8'h01 << c;
      default: t = 8'h00;
    endcase
    for (int k = 0; k < 8; k++) if (se && ((k[0] == w[0]) !== (s ? w[15] : 1'b1))) t[k] = 1'b0;
    return t;
  endfunction
  task automatic gen(int i, logic se, logic en);
    acc(1'b1, OFF_GENERATE, W[i], S[i], C[i]);
    repeat (3) @(posedge clk);
    #1 chk("delivered", {24'h0, seen}, {24'h0, en ? expect_m(W[i], S[i], C[i], se) : 8'h00});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    sec_ext = 1'b1;
    clr = 1'b0;
    req = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    acc(1'b0, OFF_GROUP_CPU, 32'h0, 1'b1, 3'h1);
    #1 chk("group reset", rdata, 32'h0);
    acc(1'b0, OFF_CONTROL, 32'h0, 1'b1, 3'h0);
    #1 chk("control reset", rdata, 32'h0);
    gen(0, 1'b1, 1'b0);
    $display("reset test done");
    acc(1'b1, OFF_CONTROL, 32'h1, 1'b1, 3'h0);
    for (int k = 0; k < 8; k++) acc(1'b1, OFF_GROUP_CPU, k[0] ? 32'haaaa : 32'h5555, 1'b1, k[2:0]);
    acc(1'b0, OFF_GROUP_CPU, 32'h0, 1'b1, 3'h3);
    #1 chk("group bank", rdata, 32'h0000aaaa);
    acc(1'b0, 8'h14, 32'h0, 1'b1, 3'h0);
    #1 chk("unmapped", rdata, 32'h0);
    for (int i = 0; i < 7; i++) gen(i, 1'b1, 1'b1);
    $display("secure table done");
    sec_ext <= 1'b0;
    for (int i = 0; i < 7; i++) gen(i, 1'b0, 1'b1);
    $display("plain table done");
    acc(1'b0, OFF_COUNT, 32'h0, 1'b1, 3'h0);
    #1 chk("counts", rdata, 32'h0000_040e);
    acc(1'b1, OFF_CONTROL, 32'h3, 1'b1, 3'h0);
    acc(1'b0, OFF_COUNT, 32'h0, 1'b1, 3'h0);
    #1 chk("counts cleared", rdata, 32'h0);
    $display("count test done");
    wrap_up;
  end
  initial begin
    repeat (1000) @(posedge clk);
    fail_count++;
    wrap_up;
  end
endmodule
bind sidsp_top sidsp_top_props u_props (.clk(clk), .rstn(rstn), .req(req), .sec_ext(sec_ext),
  .rdata(rdata), .fwd(fwd));
`default_nettype wire

// ### verif/sidsp_top_props.sv
`default_nettype none
module sidsp_top_props (
  input wire logic                  clk,     // clock
  input wire logic                  rstn,    // async reset, active low
  input wire sidsp_pkg::sidsp_req_t req,     // register access
  input wire logic                  sec_ext, // security extensions present
  input wire logic [31:0]           rdata,   // read data
  input wire sidsp_pkg::sidsp_fwd_t fwd      // forwarded interrupt
);
  import sidsp_pkg::*;
  // ----------------
  // delivery checks
  // ----------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence gen_w;
    req.wr && req.addr == OFF_GENERATE;
  endsequence
  sequence gen_f(logic [1:0] f);
    gen_w ##0 req.wdata[25:24] == f;
  endsequence
  chk_list_mask: assert property (
    gen_f(FILT_LIST) |-> ##2 (fwd.valid & ~$past(req.wdata[23:16], 2)) == 8'h00)
    else $error("delivery outside target mask");
  chk_others_skip: assert property (
    gen_f(FILT_OTHERS) |-> ##2 (fwd.valid & (8'h01 << $past(req.cpu, 2))) == 8'h00)
    else $error("broadcast reached the writer");
  chk_self_only: assert property (
    gen_f(FILT_SELF) |-> ##2 (fwd.valid & ~(8'h01 << $past(req.cpu, 2))) == 8'h00)
    else $error("self delivery reached another interface");
  chk_zero_mask: assert property (
    gen_w ##0 req.wdata[25:16] == 10'h000 |-> ##2 fwd.valid == 8'h00)
    else $error("empty mask delivered");
  chk_rsvd_filter: assert property (
    gen_f(2'h3) |-> ##2 fwd.valid == 8'h00)
    else $error("reserved filter delivered");
  chk_num_source: assert property (
    fwd.valid != 8'h00 |-> fwd.num == $past(req.wdata[3:0], 2) && fwd.source == $past(req.cpu, 2))
    else $error("wrong number or source");
  chk_valid_cause: assert property (
    fwd.valid != 8'h00 |-> $past(req.wr, 2) && $past(req.addr, 2) == OFF_GENERATE)
    else $error("delivery without a generate write");
  chk_valid_pulse: assert property (
    fwd.valid != 8'h00 |=> fwd.valid == 8'h00)
    else $error("delivery pulse too long");
endmodule
`default_nettype wire
